/* File: src/usb_ep_device.sv */
// Purpose: endpoint handshake and toggle control of the serial interface engine
// Assumes: tokens arrive on the link one at a time; register port is synchronous
// Notes:   received packet headers go out through a 16-word fifo
//
// Operation
// - isochronous tx: every transmission counts successful, completes
// - non-iso tx: hold packet until host ACK
// - successful transmit pops queue, frees buffer
// - rx iso bit suppresses OUT/SETUP handshake
// - address match starts new stored packet
// - firmware drops packets flagged bad
// - tx control 00 silent, 01 STALL
// - tx control 10 data/ACK or NAK, 11 NAK
// - rx control 00 silent, 01 STALL
// - rx control 10 ready-dependent, 11 NAK
// - tx toggle inverts after successful transmit
// - firmware changes tx toggle only when disabled
// - rx toggle shows last received data pid
// - sixteen registers, token endpoint selects one
// - firmware stalls endpoint in two steps
// - packets not split by endpoint, 0-1280 bytes
// - header byte 0 holds endpoint number
//
// Decided for this implementation: register access over APB.

`timescale 1ns/1ps
`default_nettype none

module usb_ep_device
	import ep_handshake_pkg::*;
	#(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// link to host
	usb_link_if.device            link,
	// endpoint control register port (index 0..15)
	input  wire logic             reg_wr,
	input  wire logic [3:0]       reg_idx,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	// local function address
	input  wire logic [6:0]       func_addr,
	// per-endpoint transmit queue status and receive readiness
	input  wire logic [15:0]      tx_queue_nonempty,
	input  wire logic             rx_ok,
	// transmit completion: pop queue and free buffer
	output logic                  tx_done,
	output logic      [3:0]       tx_done_ep,
	// stored packet headers toward firmware
	output logic                  hdr_valid,
	input  wire logic             hdr_ready,
	output logic      [31:0]      hdr_data
);
	// elaboration checks: the header path needs a real fifo, and the
	// control array is sized for one register per endpoint
	if (FIFO_DEPTH < 2) begin : g_fifo_depth_check
		$error("fifo depth too small");
	end
	if (NUM_ENDPOINTS != 16) begin : g_endpoint_count_check
		$error("control array holds sixteen endpoints");
	end

	// all state of the endpoint side except the header fifo in one register
	typedef struct packed {
		logic [15:0][7:0] ctrl;
		logic             pend_valid;   // IN data sent, awaiting host ACK
		logic [3:0]       pend_ep;
		logic             ans_valid;
		handshake_type    ans_hs;
		logic             ans_has_data;
		logic             ans_data_pid;
		logic             done;
		logic [3:0]       done_ep;
		logic             push;
		logic [31:0]      push_word;
	} dev_state_type;

	dev_state_type st_ff, nxt_st;
	logic          push_ready;

	// answer decode for an IN token
	function automatic handshake_type in_answer(input logic [7:0] c, input logic q);
		logic [1:0] cont;
		cont = {c[BIT_TX_HI], c[BIT_TX_LO]};
		case (cont)
			CONT_STALL:  in_answer = HS_STALL;
			CONT_NORMAL: in_answer = q ? HS_ACK : HS_NAK;
			CONT_NAK:    in_answer = HS_NAK;
			default:     in_answer = HS_NONE;
		endcase
	endfunction : in_answer

	// answer decode for an OUT/SETUP token
	function automatic handshake_type out_answer(input logic [7:0] c, input logic ok);
		logic [1:0] cont;
		cont = {c[BIT_RX_HI], c[BIT_RX_LO]};
		case (cont)
			CONT_STALL:  out_answer = HS_STALL;
			CONT_NORMAL: out_answer = ok ? HS_ACK : HS_NAK;
			CONT_NAK:    out_answer = HS_NAK;
			default:     out_answer = HS_NONE;
		endcase
		if (c[BIT_RX_ISO]) out_answer = HS_NONE;
	endfunction : out_answer

	// answer and completion outputs come straight from the state register
	assign link.tok_ready    = 1'b1;
	assign link.ans_valid    = st_ff.ans_valid;
	assign link.ans_hs       = st_ff.ans_hs;
	assign link.ans_has_data = st_ff.ans_has_data;
	assign link.ans_data_pid = st_ff.ans_data_pid;
	assign reg_rdata         = st_ff.ctrl[reg_idx];
	assign tx_done           = st_ff.done;
	assign tx_done_ep        = st_ff.done_ep;

	// token handling, completion and register writes
	always_comb begin
		logic [7:0] c;
		logic       hit;
		handshake_type hs;
		nxt_st = st_ff;
		// the token's endpoint number picks the governing control register
		c = st_ff.ctrl[link.tok_ep];
		hit = link.tok_valid && link.tok_addr == func_addr;
		hs = HS_NONE;
		nxt_st.ans_valid = 1'b0;
		nxt_st.done = 1'b0;
		// a header refused by a full fifo waits here; firmware must keep draining
		if (st_ff.push && push_ready) nxt_st.push = 1'b0;
		// firmware write; only the rx toggle bit 0 is kept apart, the tx toggle bit 1 is written
		if (reg_wr) begin
			nxt_st.ctrl[reg_idx][7:1] = reg_wdata[7:1];
		end
		// host ACK on pending IN data
		if (st_ff.pend_valid && link.host_ack) begin
			nxt_st.pend_valid = 1'b0;
			nxt_st.done = 1'b1;
			nxt_st.done_ep = st_ff.pend_ep;
			nxt_st.ctrl[st_ff.pend_ep][BIT_TX_TOGGLE] = ~st_ff.ctrl[st_ff.pend_ep][BIT_TX_TOGGLE];
		end
		// tokens are refused while IN data waits for the host's ACK
		if (hit && !st_ff.pend_valid) begin
			case (link.tok_kind)
				TOK_IN: begin
					hs = in_answer(c, tx_queue_nonempty[link.tok_ep]);
					nxt_st.ans_valid = 1'b1;
					nxt_st.ans_hs = hs;
					nxt_st.ans_has_data = hs == HS_ACK;
					nxt_st.ans_data_pid = c[BIT_TX_TOGGLE];
					if (hs == HS_ACK) begin
						if (c[BIT_TX_ISO]) begin
							nxt_st.done = 1'b1;
							nxt_st.done_ep = link.tok_ep;
							nxt_st.ctrl[link.tok_ep][BIT_TX_TOGGLE] = ~c[BIT_TX_TOGGLE];
						end else begin
							// non-iso data counts as sent only after the host's ACK
							nxt_st.pend_valid = 1'b1;
							nxt_st.pend_ep = link.tok_ep;
						end
					end
				end
				// OUT/SETUP: answer, record the toggle, queue a header
				TOK_OUT, TOK_SETUP: begin
					hs = out_answer(c, rx_ok);
					nxt_st.ans_valid = 1'b1;
					nxt_st.ans_hs = hs;
					nxt_st.ans_has_data = 1'b0;
					nxt_st.ctrl[link.tok_ep][BIT_RX_TOGGLE] = link.tok_data_pid;
					// header word: ep, toggle, bad crc / bad pid flags
					nxt_st.push = 1'b1;
					nxt_st.push_word = {16'h0000, 4'h0, link.tok_pid_ok ? 4'h0 : 4'hf,
						~link.tok_crc_ok, link.tok_data_pid, 2'b00, link.tok_ep};
				end
				default: begin
					nxt_st.ans_valid = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			// every control register clears on reset
			for (int i = 0; i < NUM_ENDPOINTS; i++) st_ff.ctrl[i] <= ENDPOINT_CONTROL_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// header fifo toward firmware
	usb_ep_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_hdr_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (st_ff.push),
		.in_ready  (push_ready),
		.in_data   (st_ff.push_word),
		.out_valid (hdr_valid),
		.out_ready (hdr_ready),
		.out_data  (hdr_data)
	);

endmodule : usb_ep_device

`default_nettype wire

/* File: pkg/ep_handshake_pkg.sv */
// Purpose: shared constants and types for the endpoint handshake controller
// Assumes: one clock pclk at 125 MHz, active-low async reset presetn
// Notes:   endpoint control registers sit at byte address index from the base, one byte each

package ep_handshake_pkg;

	// endpoint control register map in the device's own register space
	localparam logic [15:0] ENDPOINT_CONTROL_FIRST = 16'h7f80;
	localparam logic [15:0] ENDPOINT_CONTROL_LAST  = 16'h7f8f;
	localparam int          NUM_ENDPOINTS          = 16;
	localparam logic [7:0]  ENDPOINT_CONTROL_RESET = 8'h00;

	// endpoint control field positions
	localparam int BIT_TX_ISO    = 7;
	localparam int BIT_RX_ISO    = 6;
	localparam int BIT_TX_HI     = 5;
	localparam int BIT_RX_HI     = 4;
	localparam int BIT_TX_LO     = 3;
	localparam int BIT_RX_LO     = 2;
	localparam int BIT_TX_TOGGLE = 1;
	localparam int BIT_RX_TOGGLE = 0;

	// controller-side registers reached over APB (byte addresses)
	localparam logic [11:0] REG_TOKEN     = 12'h000; // w: issue token
	localparam logic [11:0] REG_STATUS    = 12'h004; // r: last answer
	localparam logic [11:0] REG_TXDATA    = 12'h008; // w: push tx word
	localparam logic [11:0] REG_RXDATA    = 12'h00c; // r: pop rx header word
	localparam logic [11:0] REG_CTRL_BASE = 12'h100; // w/r: endpoint control mirror (index*4)

	// packet header
	localparam int HDR_BYTES      = 8;
	localparam int MAX_PAYLOAD    = 1280;
	localparam logic [6:0] FUNC_ADDR_RESET = 7'h00;

	// token kinds
	typedef enum logic [1:0] {
		TOK_IN,
		TOK_OUT,
		TOK_SETUP,
		TOK_NONE
	} token_type;

	// handshake answers
	typedef enum logic [1:0] {
		HS_NONE,
		HS_ACK,
		HS_NAK,
		HS_STALL
	} handshake_type;

	// handshake control encodings
	localparam logic [1:0] CONT_DISABLED = 2'b00;
	localparam logic [1:0] CONT_STALL    = 2'b01;
	localparam logic [1:0] CONT_NORMAL   = 2'b10;
	localparam logic [1:0] CONT_NAK      = 2'b11;

endpackage : ep_handshake_pkg

/* File: pkg/usb_link_if.sv */
// Purpose: carrier between the device end and the host-side controller end
// Assumes: both ends on pclk
// Notes:   token valid/ready, device answers with a handshake and data pid

`timescale 1ns/1ps
`default_nettype none

interface usb_link_if
	import ep_handshake_pkg::*;
	(
	input wire logic pclk
	);

	// token from host
	logic          tok_valid;
	logic          tok_ready;
	token_type     tok_kind;
	logic [6:0]    tok_addr;
	logic [3:0]    tok_ep;
	logic          tok_data_pid;  // data toggle of OUT/SETUP packet
	logic          tok_pid_ok;
	logic          tok_crc_ok;
	// answer from device
	logic          ans_valid;
	handshake_type ans_hs;
	logic          ans_has_data;
	logic          ans_data_pid;
	// host handshake on IN data
	logic          host_ack;

	modport device (
		input  tok_valid, tok_kind, tok_addr, tok_ep, tok_data_pid, tok_pid_ok, tok_crc_ok, host_ack,
		output tok_ready, ans_valid, ans_hs, ans_has_data, ans_data_pid
	);

	modport host (
		output tok_valid, tok_kind, tok_addr, tok_ep, tok_data_pid, tok_pid_ok, tok_crc_ok, host_ack,
		input  tok_ready, ans_valid, ans_hs, ans_has_data, ans_data_pid
	);

endinterface : usb_link_if

`default_nettype wire

/* File: src/usb_ep_fifo.sv */
// Purpose: parameterised valid/ready fifo
// Assumes: single clock
// Notes:   honest full and empty; used on the received-header path

`timescale 1ns/1ps
`default_nettype none

module usb_ep_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// elaboration check: pointers wrap cleanly only for a power-of-two depth
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_param_check
		$error("fifo width or depth not supported");
	end

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} fifo_state_type;

	fifo_state_type st_ff, nxt_st;
	logic [WIDTH-1:0] mem [DEPTH];

	assign in_ready  = (st_ff.wr - st_ff.rd) != (AW+1)'(DEPTH);
	assign out_valid = st_ff.wr != st_ff.rd;
	assign out_data  = mem[st_ff.rd[AW-1:0]];

	// pointer update
	always_comb begin
		nxt_st = st_ff;
		if (in_valid && in_ready) nxt_st.wr = st_ff.wr + 1'b1;
		if (out_valid && out_ready) nxt_st.rd = st_ff.rd + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) st_ff <= '0;
		else st_ff <= nxt_st;
	end

	// storage write
	always_ff @(posedge pclk) begin
		if (in_valid && in_ready) mem[st_ff.wr[AW-1:0]] <= in_data;
	end

endmodule : usb_ep_fifo

`default_nettype wire

/* File: src/usb_ep_host.sv */
// Purpose: host-side controller driving tokens on the link, ordered over APB
// Assumes: apb slave, zero wait states
// Notes:   a token write issues one token; status holds the last answer

`timescale 1ns/1ps
`default_nettype none

module usb_ep_host
	import ep_handshake_pkg::*;
	(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] prdata,
	// link
	usb_link_if.host         link
);
	typedef struct packed {
		logic          tok_valid;
		token_type     kind;
		logic [6:0]    addr;
		logic [3:0]    ep;
		logic          pid;
		logic          pid_ok;
		logic          crc_ok;
		logic          auto_ack;
		logic          ack;
		logic          seen;
		handshake_type hs;
		logic          has_data;
		logic          data_pid;
		logic [31:0]   rdata;
	} host_state_type;

	host_state_type st_ff, nxt_st;

	assign pready            = 1'b1;
	assign pslverr           = 1'b0;
	assign prdata            = st_ff.rdata;
	assign link.tok_valid    = st_ff.tok_valid;
	assign link.tok_kind     = st_ff.kind;
	assign link.tok_addr     = st_ff.addr;
	assign link.tok_ep       = st_ff.ep;
	assign link.tok_data_pid = st_ff.pid;
	assign link.tok_pid_ok   = st_ff.pid_ok;
	assign link.tok_crc_ok   = st_ff.crc_ok;
	assign link.host_ack     = st_ff.ack;

	// apb access and answer capture
	always_comb begin
		logic acc;
		acc = psel && penable;
		nxt_st = st_ff;
		nxt_st.tok_valid = 1'b0;
		nxt_st.ack = 1'b0;
		if (link.ans_valid) begin
			nxt_st.seen = 1'b1;
			nxt_st.hs = link.ans_hs;
			nxt_st.has_data = link.ans_has_data;
			nxt_st.data_pid = link.ans_data_pid;
			nxt_st.ack = link.ans_has_data && st_ff.auto_ack;
		end
		if (acc && pwrite && paddr == REG_TOKEN) begin
			nxt_st.tok_valid = 1'b1;
			nxt_st.kind = token_type'(pwdata[1:0]);
			nxt_st.ep = pwdata[5:2];
			nxt_st.addr = pwdata[12:6];
			nxt_st.pid = pwdata[13];
			nxt_st.pid_ok = pwdata[14];
			nxt_st.crc_ok = pwdata[15];
			nxt_st.auto_ack = pwdata[16];
			nxt_st.seen = 1'b0;
		end
		// read data loads in the setup cycle so it stands through the access phase
		if (psel && !penable && !pwrite) begin
			case (paddr)
				REG_STATUS: nxt_st.rdata = {27'h0, st_ff.data_pid, st_ff.has_data, st_ff.hs, st_ff.seen};
				default:    nxt_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) st_ff <= '0;
		else st_ff <= nxt_st;
	end

endmodule : usb_ep_host

`default_nettype wire

/* File: dv/ep_link_properties.sv */
// Purpose: link checker for the endpoint handshake controller
// Assumes: one clock domain, async active-low reset
// Notes:   watches the link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module ep_link_properties
	import ep_handshake_pkg::*;
	(
	// clock and reset
	input wire logic          pclk,
	input wire logic          presetn,
	// link
	input wire logic          tok_valid,
	input wire token_type     tok_kind,
	input wire logic          ans_valid,
	input wire handshake_type ans_hs,
	input wire logic          ans_has_data,
	input wire logic          host_ack
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic pend_ff;
	// data sent to the host and not yet acknowledged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pend_ff <= 1'b0;
		else if (ans_valid && ans_has_data)
			pend_ff <= 1'b1;
		else if (host_ack)
			pend_ff <= 1'b0;
	end
	// the two steps of an IN data transfer
	sequence data_sent;
		ans_valid && ans_has_data;
	endsequence
	sequence ack_soon;
		##[1:8] host_ack;
	endsequence
	a_answer_cause: assert property (ans_valid |-> $past(tok_valid))
		else $error("answer without token");
	a_data_with_ack: assert property (data_sent |-> ans_hs == HS_ACK)
		else $error("data without ack");
	a_data_only_in: assert property (data_sent |-> $past(tok_kind) == TOK_IN)
		else $error("data on non-in token");
	a_in_ack_data: assert property (ans_valid && ans_hs == HS_ACK && $past(tok_kind) == TOK_IN |-> ans_has_data)
		else $error("in ack without data");
	a_host_acks: assert property (data_sent |-> ack_soon)
		else $error("data never acknowledged");
	a_ack_follows: assert property (host_ack |-> pend_ff)
		else $error("ack without data");
	a_hold_pending: assert property (ans_valid |-> !pend_ff)
		else $error("answer while ack pending");
	a_token_pulse: assert property (tok_valid |=> !tok_valid)
		else $error("token held too long");
endmodule : ep_link_properties
`default_nettype wire

/* File: dv/usb_endpoint_handshake_control_bench.sv */
// Purpose: self-checking bench for both ends of the endpoint handshake link
// Assumes: 125 MHz pclk, host end ordered over apb
// Notes:   register reset and write checks first, then table rows, toggle, refusal, status and fifo cases
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_handshake_control_bench
	import ep_handshake_pkg::*;
	;
	typedef struct packed {
		logic [3:0]    ep;
		logic [7:0]    ctrl;
		token_type     kind;
		logic          go;
		handshake_type hs;
	} row_type;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h0;
	logic          reg_wr = 1'b0;
	logic [3:0]    reg_idx = 4'h0;
	logic [7:0]    reg_wdata = 8'h00;
	logic [15:0]   tx_queue_nonempty = 16'h0000;
	logic          rx_ok = 1'b0;
	logic          hdr_ready = 1'b1;
	logic          pready, pslverr, tx_done, hdr_valid, got, a_dat, a_pid, e;
	logic [7:0]    reg_rdata;
	logic [3:0]    tx_done_ep, last_ep;
	logic [31:0]   prdata, hdr_data, q;
	handshake_type a_hs;
	int            bad_count = 0, comparisons = 0, done_cnt = 0, n, k;
	row_type rows [14] = '{
		'{4'h0, 8'h00, TOK_IN, 1'b1, HS_NONE},
		'{4'h1, 8'h08, TOK_IN, 1'b1, HS_STALL},
		'{4'h2, 8'h20, TOK_IN, 1'b1, HS_ACK},
		'{4'h3, 8'h20, TOK_IN, 1'b0, HS_NAK},
		'{4'h4, 8'h28, TOK_IN, 1'b1, HS_NAK},
		'{4'h5, 8'ha0, TOK_IN, 1'b1, HS_ACK},
		'{4'h6, 8'h00, TOK_OUT, 1'b1, HS_NONE},
		'{4'h7, 8'h04, TOK_OUT, 1'b1, HS_STALL},
		'{4'h8, 8'h10, TOK_OUT, 1'b1, HS_ACK},
		'{4'h9, 8'h10, TOK_OUT, 1'b0, HS_NAK},
		'{4'ha, 8'h14, TOK_OUT, 1'b1, HS_NAK},
		'{4'hb, 8'h50, TOK_OUT, 1'b1, HS_NONE},
		'{4'hc, 8'h50, TOK_SETUP, 1'b1, HS_NONE},
		'{4'hd, 8'h10, TOK_SETUP, 1'b1, HS_ACK}
	};
	// free-running clock, 8 ns period
	always #4 pclk = ~pclk;
	// count transmit completions
	always @(posedge pclk)
		if (tx_done) begin
			done_cnt <= done_cnt + 1;
			last_ep  <= tx_done_ep;
		end
	usb_link_if link (.pclk(pclk));
	usb_ep_device #(.FIFO_DEPTH(16)) usb_ep_device_i (.pclk(pclk), .presetn(presetn), .link(link),
		.reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .func_addr(7'h05),
		.tx_queue_nonempty(tx_queue_nonempty), .rx_ok(rx_ok), .tx_done(tx_done), .tx_done_ep(tx_done_ep),
		.hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_data(hdr_data));
	usb_ep_host usb_ep_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .link(link));
	ep_link_properties ep_link_properties_i (.pclk(pclk), .presetn(presetn), .tok_valid(link.tok_valid),
		.tok_kind(link.tok_kind), .ans_valid(link.ans_valid), .ans_hs(link.ans_hs),
		.ans_has_data(link.ans_has_data), .host_ack(link.host_ack));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic stop_test;
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			stop_test;
		end
	endtask : apb
	task automatic token(input token_type kd, input logic [3:0] ep, input logic [6:0] ad, input logic pid);
		int t;
		apb(1'b1, REG_TOKEN, {15'h0000, 1'b1, 2'b11, pid, ad, ep, kd});
		got = 1'b0;
		for (t = 0; t < 6 && !got; t++) begin
			@(posedge pclk);
			#1;
			got = link.ans_valid;
			a_hs = link.ans_hs;
			a_dat = link.ans_has_data;
			a_pid = link.ans_data_pid;
		end
	endtask : token
	task automatic wreg(input logic [3:0] i, input logic [7:0] v);
		@(posedge pclk);
		reg_wr <= 1'b1;
		reg_idx <= i;
		reg_wdata <= v;
		@(posedge pclk);
		reg_wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [3:0] i);
		@(posedge pclk);
		reg_idx <= i;
		@(posedge pclk);
		#1;
		q = {24'h0, reg_rdata};
	endtask : rreg
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 16; k++) begin
			rreg(k[3:0]);
			check(q, 32'h0);
		end
		wreg(4'hf, 8'hff);
		rreg(4'hf);
		check(q, 32'hfe);
		foreach (rows[i]) begin
			wreg(rows[i].ep, rows[i].ctrl);
			tx_queue_nonempty <= {16{rows[i].go}};
			rx_ok <= rows[i].go;
			e = rows[i].hs == HS_ACK && rows[i].kind == TOK_IN;
			n = done_cnt;
			token(rows[i].kind, rows[i].ep, 7'h05, 1'b1);
			check(got ? a_hs : HS_NONE, rows[i].hs);
			check(got & a_dat, e);
			for (k = 0; k < 10 && done_cnt == n; k++)
				@(posedge pclk);
			check(done_cnt, n + e);
			if (e)
				check({a_pid, last_ep}, {1'b0, rows[i].ep});
			if (rows[i].hs == HS_ACK) begin
				rreg(rows[i].ep);
				check(q, e ? rows[i].ctrl ^ 8'h02 : rows[i].ctrl | 8'h01);
			end
		end
		// back-to-back transfers alternate the data toggle
		for (k = 0; k < 2; k++) begin
			token(TOK_IN, 4'h2, 7'h05, 1'b0);
			check(a_pid, k == 0);
		end
		token(TOK_IN, 4'h2, 7'h06, 1'b0);
		check(got, 1'b0);
		token(TOK_IN, 4'h1, 7'h05, 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		check(q[3:0], 4'h7);
		apb(1'b0, 12'h7fc, 32'h0);
		check(pslverr, 1'b0);
		// tx toggle preset while the endpoint is off, then used by the next IN
		wreg(4'h3, 8'h00);
		wreg(4'h3, 8'h02);
		rreg(4'h3);
		check(q, 32'h02);
		wreg(4'h3, 8'h22);
		token(TOK_IN, 4'h3, 7'h05, 1'b0);
		check(a_pid, 1'b1);
		// stall an endpoint in two steps: off line first, then stall
		wreg(4'h9, 8'h00);
		wreg(4'h9, 8'h04);
		token(TOK_OUT, 4'h9, 7'h05, 1'b0);
		check(got ? a_hs : HS_NONE, HS_STALL);
		// fill the header fifo with the drain stalled, then empty it
		wreg(4'h8, 8'h10);
		hdr_ready <= 1'b0;
		for (k = 0; k < 17; k++)
			token(TOK_OUT, 4'h8, 7'h05, 1'b1);
		n = 0;
		@(posedge pclk);
		hdr_ready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			#1;
			if (hdr_valid) begin
				n++;
				check(hdr_data[3:0], 4'h8);
			end
			@(posedge pclk);
		end
		// sixteen headers held in the fifo and one waiting in the push stage
		check(n, 17);
		// bad pid and bad crc are flagged in the header for firmware to drop
		hdr_ready <= 1'b0;
		apb(1'b1, REG_TOKEN, {15'h0000, 1'b1, 2'b00, 1'b0, 7'h05, 4'h8, TOK_OUT});
		repeat (4) @(posedge pclk);
		#1;
		check({hdr_valid, hdr_data[11:0]}, 13'h1f88);
		@(posedge pclk);
		hdr_ready <= 1'b1;
		@(posedge pclk);
		#1;
		check(hdr_valid, 1'b0);
		stop_test;
	end
endmodule : usb_endpoint_handshake_control_bench
`default_nettype wire
